//--- logic/irq_enable_priority_regs.sv
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps

module irq_enable_priority_regs (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [7:0]               haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Peripheral request pulses, same clock
  input  wire logic [15:0]              src_req2,
  input  wire logic [15:0]              src_req3,
  input  wire logic [15:0]              src_req4,
  input  wire logic [11:0]              src_req_prio,
  // Device variant strap
  input  wire logic                     can_present,
  // Toward the processor
  output logic      [15:0]              pend2,
  output logic      [15:0]              pend3,
  output logic      [15:0]              pend4,
  output irq_regs_pkg::fwd_req_t        fwd_req,
  output logic                          irq
);
  import irq_regs_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic        wr_pend_q;      // Write data phase pending
  logic [7:0]  wr_addr_q;      // Latched write address
  logic        rd_pend_q;      // Read data phase pending
  logic [7:0]  rd_addr_q;      // Latched read address
  logic [15:0] en2_q;          // Enable group two
  logic [15:0] en3_q;          // Enable group three
  logic [15:0] en4_q;          // Enable group four
  logic [15:0] prio0_q;        // Priority bank zero
  logic [15:0] prio1_q;        // Priority bank one
  logic [15:0] prio2_q;        // Priority bank two
  logic [15:0] flag2_q;        // Sticky source flags
  logic [15:0] flag3_q;
  logic [15:0] flag4_q;
  logic [11:0] pflag_q;        // Flags of prioritised sources
  logic [1:0]  st_q;           // Block interrupt status
  logic [1:0]  msk_q;          // Block interrupt mask
  logic        can_meta_q;     // Strap, first sync stage
  logic        can_sync_q;     // Strap, second sync stage
  logic [1:0]  can_arm_q;      // Sync stages filled since reset
  logic        can_q;          // Strap caught after reset
  logic        can_done_q;     // Strap capture finished
  logic [15:0] can2_gate;      // CAN bits forced off when absent
  logic [15:0] can4_gate;
  logic [15:0] wdat;           // Write data, low half
  logic        wr_take;        // Write data phase now
  logic        addr_ok;        // Read address decodes
  logic [11:0] pflag_clr;      // Software clear of prio flags
  logic [1:0]  evt;            // Block events this cycle
  logic [2:0]  lvl [NPRIO];    // Level per prioritised source
  logic [31:0] rd_mux;         // Read data selection
  fwd_req_t    fwd_d;          // Next forwarded request
  logic        ahb_go;         // Valid transfer in address phase
  logic [15:0] en2_eff;        // Enable two, implemented bits only
  logic [15:0] en3_eff;        // Enable three, implemented bits only
  logic [15:0] en4_eff;        // Enable four, implemented bits only
  // Named priority fields, three bits each
  logic [2:0]  ext_pin_a_prio;     // Bank zero, lowest field
  logic [2:0]  in_capture_a_prio;  // Bank zero
  logic [2:0]  out_compare_a_prio; // Bank zero
  logic [2:0]  timer_a_prio;       // Bank zero, top field
  logic [2:0]  dma_ch0_done_prio;  // Bank one, lowest field
  logic [2:0]  in_capture_b_prio;  // Bank one
  logic [2:0]  out_compare_b_prio; // Bank one
  logic [2:0]  timer_b_prio;       // Bank one, top field
  logic [2:0]  timer_c_prio;       // Bank two, lowest field
  logic [2:0]  spi_a_error_prio;   // Bank two
  logic [2:0]  spi_a_event_prio;   // Bank two
  logic [2:0]  serial_a_rx_prio;   // Bank two, top field

  // ------------------------------------------------------------
  // Bus front end
  // ------------------------------------------------------------
  assign ahb_go    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;      // Zero wait states, always OKAY
  assign hresp     = 1'b0;
  assign wdat      = hwdata[15:0];
  assign wr_take   = wr_pend_q;

  // Latch address phase into data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ahb_go & hwrite;
      rd_pend_q <= ahb_go & ~hwrite;
      if (ahb_go) begin
        wr_addr_q <= haddr;
        rd_addr_q <= haddr;
      end
    end
  end

  // ------------------------------------------------------------
  // Variant strap capture
  // ------------------------------------------------------------
  // Two stages first: the strap is a pin, not a clocked signal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_meta_q <= 1'b0;
      can_sync_q <= 1'b0;
      can_arm_q  <= 2'b00;
    end else begin
      can_meta_q <= can_present;
      can_sync_q <= can_meta_q;
      can_arm_q  <= {can_arm_q[0], 1'b1};
    end
  end

  // Caught once both stages hold post-reset samples; until then
  // the CAN bits stay gated off, which is the safe side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_q      <= 1'b0;
      can_done_q <= 1'b0;
    end else if (can_arm_q[1] && !can_done_q) begin
      can_q      <= can_sync_q;
      can_done_q <= 1'b1;
    end
  end

  // Without a controller the CAN bits can never be set
  assign can2_gate = can_q ? 16'hFFFF : ~CAN2_MASK;
  assign can4_gate = can_q ? 16'hFFFF : ~CAN4_MASK;

  // ------------------------------------------------------------
  // Enable registers
  // ------------------------------------------------------------
  // Whole-word write, effective next clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en2_q <= EN_RST;
      en3_q <= EN_RST;
      en4_q <= EN_RST;
    end else begin
      if (wr_take && wr_addr_q == OFS_EN2) begin
        en2_q <= wdat & EN2_MASK & can2_gate;
      end else begin
        en2_q <= en2_q & can2_gate;
      end
      if (wr_take && wr_addr_q == OFS_EN3) begin
        en3_q <= wdat & EN3_MASK;
      end
      if (wr_take && wr_addr_q == OFS_EN4) begin
        en4_q <= wdat & EN4_MASK & can4_gate;
      end else begin
        en4_q <= en4_q & can4_gate;
      end
    end
  end

  // Effective enables rebuilt from the named positions only, so a
  // reserved bit can never reach a pending output
  always_comb begin
    en2_eff = 16'h0000;
    en3_eff = 16'h0000;
    en4_eff = 16'h0000;
    en2_eff[DMA_CH4_DONE_IRQ_EN]   = en2_q[DMA_CH4_DONE_IRQ_EN];
    en2_eff[PARALLEL_PORT_IRQ_EN]  = en2_q[PARALLEL_PORT_IRQ_EN];
    en2_eff[DMA_CH3_DONE_IRQ_EN]   = en2_q[DMA_CH3_DONE_IRQ_EN];
    en2_eff[CAN_EVENT_IRQ_EN]      = en2_q[CAN_EVENT_IRQ_EN];
    en2_eff[CAN_RX_READY_IRQ_EN]   = en2_q[CAN_RX_READY_IRQ_EN];
    en2_eff[SPI_B_EVENT_IRQ_EN]    = en2_q[SPI_B_EVENT_IRQ_EN];
    en2_eff[SPI_B_ERROR_IRQ_EN]    = en2_q[SPI_B_ERROR_IRQ_EN];
    en3_eff[CALENDAR_IRQ_EN]       = en3_q[CALENDAR_IRQ_EN];
    en3_eff[DMA_CH5_DONE_IRQ_EN]   = en3_q[DMA_CH5_DONE_IRQ_EN];
    en4_eff[CAN_TX_REQUEST_IRQ_EN] = en4_q[CAN_TX_REQUEST_IRQ_EN];
    en4_eff[DMA_CH7_DONE_IRQ_EN]   = en4_q[DMA_CH7_DONE_IRQ_EN];
    en4_eff[DMA_CH6_DONE_IRQ_EN]   = en4_q[DMA_CH6_DONE_IRQ_EN];
    en4_eff[CHECKSUM_GEN_IRQ_EN]   = en4_q[CHECKSUM_GEN_IRQ_EN];
    en4_eff[SERIAL_B_ERROR_IRQ_EN] = en4_q[SERIAL_B_ERROR_IRQ_EN];
    en4_eff[SERIAL_A_ERROR_IRQ_EN] = en4_q[SERIAL_A_ERROR_IRQ_EN];
  end

  // ------------------------------------------------------------
  // Priority registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio0_q <= PRIO_RST;
      prio1_q <= PRIO_RST;
      prio2_q <= PRIO_RST;
    end else if (wr_take) begin
      // Separator bits masked off
      if (wr_addr_q == OFS_PRIO0) begin
        prio0_q <= wdat & PRIO_MASK;
      end
      if (wr_addr_q == OFS_PRIO1) begin
        prio1_q <= wdat & PRIO_MASK;
      end
      if (wr_addr_q == OFS_PRIO2) begin
        prio2_q <= wdat & PRIO_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // Named priority fields
  // ------------------------------------------------------------
  // Bank zero
  assign ext_pin_a_prio     = prio0_q[PRIO_F0 +: 3];
  assign in_capture_a_prio  = prio0_q[PRIO_F1 +: 3];
  assign out_compare_a_prio = prio0_q[PRIO_F2 +: 3];
  assign timer_a_prio       = prio0_q[PRIO_F3 +: 3];
  // Bank one
  assign dma_ch0_done_prio  = prio1_q[PRIO_F0 +: 3];
  assign in_capture_b_prio  = prio1_q[PRIO_F1 +: 3];
  assign out_compare_b_prio = prio1_q[PRIO_F2 +: 3];
  assign timer_b_prio       = prio1_q[PRIO_F3 +: 3];
  // Bank two
  assign timer_c_prio       = prio2_q[PRIO_F0 +: 3];
  assign spi_a_error_prio   = prio2_q[PRIO_F1 +: 3];
  assign spi_a_event_prio   = prio2_q[PRIO_F2 +: 3];
  assign serial_a_rx_prio   = prio2_q[PRIO_F3 +: 3];

  // Source order: 0..3 bank0 low..high, 4..7 bank1, 8..11 bank2
  always_comb begin
    lvl[0]  = ext_pin_a_prio;
    lvl[1]  = in_capture_a_prio;
    lvl[2]  = out_compare_a_prio;
    lvl[3]  = timer_a_prio;
    lvl[4]  = dma_ch0_done_prio;
    lvl[5]  = in_capture_b_prio;
    lvl[6]  = out_compare_b_prio;
    lvl[7]  = timer_b_prio;
    lvl[8]  = timer_c_prio;
    lvl[9]  = spi_a_error_prio;
    lvl[10] = spi_a_event_prio;
    lvl[11] = serial_a_rx_prio;
  end

  // ------------------------------------------------------------
  // Source flags
  // ------------------------------------------------------------
  // Write one to clear; a request in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag2_q <= 16'h0000;
      flag3_q <= 16'h0000;
      flag4_q <= 16'h0000;
    end else begin
      flag2_q <= ((flag2_q & ~((wr_take && wr_addr_q == OFS_FLAG2) ? wdat : 16'h0000))
                  | src_req2) & EN2_MASK & can2_gate;
      flag3_q <= ((flag3_q & ~((wr_take && wr_addr_q == OFS_FLAG3) ? wdat : 16'h0000))
                  | src_req3) & EN3_MASK;
      flag4_q <= ((flag4_q & ~((wr_take && wr_addr_q == OFS_FLAG4) ? wdat : 16'h0000))
                  | src_req4) & EN4_MASK & can4_gate;
    end
  end

  // Prioritised source flags cleared by writing ones to the low 12 bits of the CFG register
  assign pflag_clr = (wr_take && wr_addr_q == OFS_CFG) ? wdat[11:0] : 12'h000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pflag_q <= 12'h000;
    end else begin
      pflag_q <= (pflag_q & ~pflag_clr) | src_req_prio;
    end
  end

  // ------------------------------------------------------------
  // Pending outputs and forwarded request
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend2 <= 16'h0000;
      pend3 <= 16'h0000;
      pend4 <= 16'h0000;
    end else begin
      pend2 <= flag2_q & en2_eff;
      pend3 <= flag3_q & en3_eff;
      pend4 <= flag4_q & en4_eff;
    end
  end

  // Highest level wins; ties go to the lower source index
  always_comb begin
    fwd_d = '0;
    for (int i = 0; i < NPRIO; i++) begin
      if (pflag_q[i] && lvl[i] != 3'b000 && lvl[i] > fwd_d.level) begin
        fwd_d.valid  = 1'b1;
        fwd_d.source = 4'(i);
        fwd_d.level  = lvl[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_req <= '0;
    end else begin
      fwd_req <= fwd_d;
    end
  end

  // ------------------------------------------------------------
  // Block interrupt status and mask
  // ------------------------------------------------------------
  assign addr_ok = (rd_addr_q <= OFS_CFG) && (rd_addr_q[1:0] == 2'b00);
  assign evt[EVT_UNMAPPED] = (wr_pend_q && (wr_addr_q > OFS_CFG || wr_addr_q[1:0] != 2'b00))
                           | (rd_pend_q && !addr_ok);
  // Request arrived while its enable was clear
  assign evt[EVT_DROPPED] = (|(src_req2 & ~en2_eff)) | (|(src_req3 & ~en3_eff))
                          | (|(src_req4 & ~en4_eff));

  // Set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= ST_RST[1:0];
      msk_q <= ST_RST[1:0];
    end else begin
      st_q <= (st_q & ~((wr_take && wr_addr_q == OFS_IRQ_ST) ? wdat[1:0] : 2'b00)) | evt;
      if (wr_take && wr_addr_q == OFS_IRQ_MSK) begin
        msk_q <= wdat[1:0];
      end
    end
  end

  assign irq = |(st_q & msk_q);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_addr_q)
      OFS_EN2:     rd_mux = {16'h0000, en2_q};
      OFS_EN3:     rd_mux = {16'h0000, en3_q};
      OFS_EN4:     rd_mux = {16'h0000, en4_q};
      OFS_PRIO0:   rd_mux = {16'h0000, prio0_q};
      OFS_PRIO1:   rd_mux = {16'h0000, prio1_q};
      OFS_PRIO2:   rd_mux = {16'h0000, prio2_q};
      OFS_FLAG2:   rd_mux = {16'h0000, flag2_q};
      OFS_FLAG3:   rd_mux = {16'h0000, flag3_q};
      OFS_FLAG4:   rd_mux = {16'h0000, flag4_q};
      OFS_IRQ_ST:  rd_mux = {30'h0, st_q};
      OFS_IRQ_MSK: rd_mux = {30'h0, msk_q};
      OFS_CFG:     rd_mux = {15'h0, can_q, 4'h0, pflag_q};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // Data phase output is combinational from latched address
  assign hrdata = rd_pend_q ? rd_mux : 32'h0000_0000;

endmodule

//--- logic/irq_regs_pkg.sv
package irq_regs_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_EN2     = 8'h00;
  localparam logic [7:0] OFS_EN3     = 8'h04;
  localparam logic [7:0] OFS_EN4     = 8'h08;
  localparam logic [7:0] OFS_PRIO0   = 8'h0C;
  localparam logic [7:0] OFS_PRIO1   = 8'h10;
  localparam logic [7:0] OFS_PRIO2   = 8'h14;
  localparam logic [7:0] OFS_FLAG2   = 8'h18;
  localparam logic [7:0] OFS_FLAG3   = 8'h1C;
  localparam logic [7:0] OFS_FLAG4   = 8'h20;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h24;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h28;
  localparam logic [7:0] OFS_CFG     = 8'h2C;

  // ------------------------------------------------------------
  // Writable bit masks (unimplemented bits stay zero)
  // ------------------------------------------------------------
  localparam logic [15:0] EN2_MASK  = 16'h601F;
  localparam logic [15:0] EN3_MASK  = 16'h6000;
  localparam logic [15:0] EN4_MASK  = 16'h007E;
  localparam logic [15:0] PRIO_MASK = 16'h7777;
  localparam logic [15:0] CAN2_MASK = 16'h000C;
  localparam logic [15:0] CAN4_MASK = 16'h0040;

  // ------------------------------------------------------------
  // Enable bit positions
  // ------------------------------------------------------------
  localparam int DMA_CH4_DONE_IRQ_EN   = 14;
  localparam int PARALLEL_PORT_IRQ_EN  = 13;
  localparam int DMA_CH3_DONE_IRQ_EN   = 4;
  localparam int CAN_EVENT_IRQ_EN      = 3;
  localparam int CAN_RX_READY_IRQ_EN   = 2;
  localparam int SPI_B_EVENT_IRQ_EN    = 1;
  localparam int SPI_B_ERROR_IRQ_EN    = 0;
  localparam int CALENDAR_IRQ_EN       = 14;
  localparam int DMA_CH5_DONE_IRQ_EN   = 13;
  localparam int CAN_TX_REQUEST_IRQ_EN = 6;
  localparam int DMA_CH7_DONE_IRQ_EN   = 5;
  localparam int DMA_CH6_DONE_IRQ_EN   = 4;
  localparam int CHECKSUM_GEN_IRQ_EN   = 3;
  localparam int SERIAL_B_ERROR_IRQ_EN = 2;
  localparam int SERIAL_A_ERROR_IRQ_EN = 1;

  // Priority field low positions (fields are 3 bits)
  localparam int PRIO_F3 = 12;
  localparam int PRIO_F2 = 8;
  localparam int PRIO_F1 = 4;
  localparam int PRIO_F0 = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] EN_RST   = 16'h0000;
  localparam logic [15:0] PRIO_RST = 16'h4444;
  localparam logic [15:0] ST_RST   = 16'h0000;

  // Interrupt status event bits
  localparam int EVT_UNMAPPED = 0;
  localparam int EVT_DROPPED  = 1;

  // Number of prioritised sources
  localparam int NPRIO = 12;

  // Forwarded request toward the processor
  typedef struct packed {
    logic       valid;
    logic [3:0] source;
    logic [2:0] level;
  } fwd_req_t;

endpackage

//--- dv/irq_regs_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for enables and priorities
// ----------------------------------------
module irq_regs_assertions
  import irq_regs_pkg::*;
(
  // Clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // Bus side
  input wire logic                   hsel,
  input wire logic [7:0]             haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // Request side
  input wire logic                   can_present,
  input wire logic [15:0]            pend2,
  input wire logic [15:0]            pend3,
  input wire logic [15:0]            pend4,
  input wire irq_regs_pkg::fwd_req_t fwd_req
);
  logic rd_go;  // Read taken in this address phase
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase of a read
  sequence rd_take;
    rd_go;
  endsequence
  // Read aimed at a hole or off word alignment
  sequence rd_hole;
    rd_take ##0 (haddr > OFS_CFG || haddr[1:0] != 2'h0);
  endsequence
  a_never_wait: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_idle_zero: assert property (!rd_go |=> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_upper_zero: assert property (rd_go && haddr != OFS_CFG |=> hrdata[31:16] == 16'h0)
    else $error("upper half of read data not zero");
  a_hole_zero: assert property (rd_hole |=> hrdata == 32'h0)
    else $error("hole read returned data");
  a_pend_holes: assert property (((pend2 & ~EN2_MASK) | (pend4 & ~EN4_MASK)) == 16'h0)
    else $error("pending on an unimplemented bit");
  a_pend_three: assert property ((pend3 & ~EN3_MASK) == 16'h0)
    else $error("pending on a reserved group three bit");
  a_can_quiet: assert property (!can_present |-> ((pend2 & CAN2_MASK) | (pend4 & CAN4_MASK)) == 16'h0)
    else $error("CAN source pending without controller");
  a_fwd_level: assert property (fwd_req.valid |-> fwd_req.level != 3'h0)
    else $error("level zero forwarded");
  a_fwd_source: assert property (fwd_req.valid |-> fwd_req.source < 4'hC)
    else $error("forwarded source out of range");
endmodule

bind irq_enable_priority_regs irq_regs_assertions u_chk (.*);

//--- dv/irq_src_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Peripheral sources: one-cycle request pulses
// ----------------------------------------
module irq_src_model (
  // Clock
  input  wire logic        hclk,
  // Command from the bench
  input  wire logic        go,
  input  wire logic [59:0] cmd,
  // Pulses toward the block, idle low
  output logic      [15:0] src_req2 = 16'h0000,
  output logic      [15:0] src_req3 = 16'h0000,
  output logic      [15:0] src_req4 = 16'h0000,
  output logic      [11:0] src_req_prio = 12'h000
);
  // Drop back to idle so a stale pulse is never seen twice
  always @(posedge hclk) begin
    src_req2     <= go ? cmd[15:0] : 16'h0000;
    src_req3     <= go ? cmd[31:16] : 16'h0000;
    src_req4     <= go ? cmd[47:32] : 16'h0000;
    src_req_prio <= go ? cmd[59:48] : 12'h000;
  end
endmodule

//--- dv/tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench with a reference model of the registers
// ----------------------------------------
module tb;
  import irq_regs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, can_present, go;  // Bus and strap drive
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, d;
  logic        hreadyout, hresp, irq;
  logic [15:0] src_req2, src_req3, src_req4, pend2, pend3, pend4;
  logic [11:0] src_req_prio, m_pf;
  logic [59:0] cmd;
  fwd_req_t    fwd_req;
  logic [15:0] m_en[3], m_pr[3], m_fl[3];  // Reference state
  int          miscompares = 0, total_checks = 0, seed = 81;

  always #20 hclk = ~hclk;

  irq_src_model u_src (.*);
  irq_enable_priority_regs u_dut (.hready(hreadyout), .*);

  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Single transfer; waits on ready, read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  // Implemented bits of a group; CAN bits drop out when absent
  function automatic logic [15:0] em(input int g);
    logic [15:0] m;
    m = (g == 0) ? EN2_MASK : (g == 1) ? EN3_MASK : EN4_MASK;
    if (can_present !== 1'b1) begin
      m = m & ~((g == 0) ? CAN2_MASK : (g == 2) ? CAN4_MASK : 16'h0000);
    end
    return m;
  endfunction

  // Highest nonzero level wins, ties to the lower index
  function automatic logic [7:0] fwd_exp();
    int b, l, v;
    b = 0;
    l = 0;
    for (int i = 0; i < NPRIO; i++) begin
      v = (m_pr[i / 4] >> (4 * (i % 4))) & 7;
      if (m_pf[i] && v > l) begin
        b = i;
        l = v;
      end
    end
    return (l > 0) ? {1'b1, 4'(b), 3'(l)} : 8'h00;
  endfunction

  // Strap is held across the whole reset pulse
  task automatic rst(input logic c);
    @(posedge hclk);
    hresetn     <= 1'b0;
    can_present <= c;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    m_en = '{default: EN_RST};
    m_pr = '{default: PRIO_RST};
    m_fl = '{default: 16'h0000};
    m_pf = 12'h000;
  endtask

  // Pulse requests, wait for flag then pend, then update the model
  task automatic fire(input logic [59:0] c);
    @(posedge hclk);
    cmd <= c;
    go  <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    for (int g = 0; g < 3; g++) m_fl[g] |= c[16 * g +: 16] & em(g);
    m_pf |= c[59:48];
  endtask

  initial begin
    {hclk, hresetn, hsel, hwrite, go, can_present} = 6'b000001;
    {haddr, htrans, hsize, hwdata, cmd} = {8'h00, 2'h0, 3'h2, 32'h0, 60'h0};
    for (int c = 1; c >= 0; c--) begin
      rst(c[0]);
      for (int i = 0; i < 6; i++) rdc(8'(4 * i), (i < 3) ? 32'h0 : {16'h0, PRIO_RST});
      // All ones first, then random words
      for (int k = 0; k < 4; k++) begin
        for (int g = 0; g < 3; g++) begin
          d = (k == 0) ? 32'hFFFFFFFF : $random(seed);
          bus(8'(4 * g), 1'b1, d);
          m_en[g] = d[15:0] & em(g);
          rdc(8'(4 * g), {16'h0, m_en[g]});
          d = (k == 0) ? 32'hFFFFFFFF : $random(seed);
          bus(8'(12 + 4 * g), 1'b1, d);
          m_pr[g] = d[15:0] & PRIO_MASK;
          rdc(8'(12 + 4 * g), {16'h0, m_pr[g]});
        end
        fire(60'({$random(seed), $random(seed)}));
        chk({pend4, pend2}, {m_fl[2] & m_en[2], m_fl[0] & m_en[0]});
        chk({16'h0, pend3}, {16'h0, m_fl[1] & m_en[1]});
        chk(32'(fwd_req.valid ? {fwd_req} : 8'h00), 32'(fwd_exp()));
        for (int g = 0; g < 3; g++) begin
          rdc(8'(OFS_FLAG2 + 4 * g), {16'h0, m_fl[g]});
          bus(8'(OFS_FLAG2 + 4 * g), 1'b1, 32'hFFFF);
        end
        bus(OFS_CFG, 1'b1, 32'hFFF);
        m_fl = '{default: 16'h0000};
        m_pf = 12'h000;
        rdc(OFS_CFG, {15'h0, c[0], 16'h0});
        chk({31'h0, fwd_req.valid}, 32'h0);
      end
      // Holes raise status; mask gates the interrupt line
      bus(OFS_IRQ_ST, 1'b1, 32'h3);
      rdc(8'h30, 32'h0);
      rdc(8'h02, 32'h0);
      rdc(OFS_IRQ_ST, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(OFS_IRQ_MSK, 1'b1, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(OFS_IRQ_ST, 1'b1, 32'h1);
      chk({31'h0, irq}, 32'h0);
    end
    test_done();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    test_done();
  end
endmodule
